/* rtl/mpw_top.sv */
// program paging, data window and data-space decode of the core's memory system
// assumes the core drives data and fetch requests on clk_i; program memory and the
// eeprom controller answer combinationally in the same cycle
`timescale 1ns/10ps
`default_nettype none
`include "mpw_params.svh"
module mpw_top
  import mpw_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = `MPW_STACK_DEPTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  // core data access
  input wire logic dat_wr_i,
  input wire logic dat_rd_i,
  input wire logic dat_bitop_i,
  input wire logic [`MPW_DAT_W-1:0] dat_addr_i,
  input wire logic [`MPW_DAT_W-1:0] dat_wdata_i,
  output logic [`MPW_DAT_W-1:0] dat_rdata_o,
  output logic dat_rvalid_o,
  output logic dat_hit_o,
  // one-hot bank select from the bank register
  input wire logic [`MPW_BSEL_W-1:0] bank_sel_i,
  // eeprom controller
  output logic eep_cs_o,
  output logic eep_we_o,
  output logic eep_page_o,
  output logic [`MPW_WIN_OFS_W-1:0] eep_addr_o,
  output logic [`MPW_DAT_W-1:0] eep_wdata_o,
  input wire logic [`MPW_DAT_W-1:0] eep_rdata_i,
  // instruction fetch
  input wire logic [`MPW_PC_W-1:0] pc_i,
  output logic [`MPW_PROG_AW-1:0] fetch_addr_o,
  // second program memory port: data window and external readout
  output logic [`MPW_PROG_AW-1:0] rom_b_addr_o,
  input wire logic [`MPW_DAT_W-1:0] rom_b_data_i,
  // external readout
  input wire logic readout_prot_i,
  input wire logic ext_rd_i,
  input wire logic [`MPW_PROG_AW-1:0] ext_addr_i,
  output logic ext_rd_ack_o,
  output logic [`MPW_DAT_W-1:0] ext_rdata_o,
  output logic ext_rvalid_o,
  output logic ext_denied_o,
  // return address stack
  input wire logic stk_push_i,
  input wire logic stk_pop_i,
  input wire logic [`MPW_PC_W-1:0] stk_push_data_i,
  output logic [`MPW_PC_W-1:0] stk_top_o,
  output logic [$clog2(STACK_DEPTH+1)-1:0] stk_depth_o
);
  mpw_region_e region;
  logic wr_page;
  logic wr_base;
  logic win_rd;
  logic bank_one;
  logic bank_ram_sel;
  logic [1:0] bank_idx;
  logic [`MPW_PAGE_W-1:0] page_q;
  logic [`MPW_PAGE_W-1:0] page_d;
  logic [`MPW_WIN_BASE_W-1:0] base_q;
  logic [`MPW_WIN_BASE_W-1:0] base_d;
  logic [`MPW_PAGE_W-1:0] eff_page;
  logic prot_meta_q;
  logic prot_q;
  logic [`MPW_DAT_W-1:0] rdata_q;
  logic [`MPW_DAT_W-1:0] rdata_d;
  logic rvalid_q;
  logic hit_q;
  logic hit_d;
  logic [`MPW_DAT_W-1:0] ext_rdata_q;
  logic [`MPW_DAT_W-1:0] ext_rdata_d;
  logic ext_rvalid_q;
  logic ext_denied_q;
  logic [`MPW_DAT_W-1:0] gp_rdata;
  logic [`MPW_DAT_W-1:0] bank_rdata;
  logic [`MPW_DAT_W-1:0] gp_ofs;

  // data space decode
  always_comb begin
    region = MPW_RG_NONE;
    if (dat_addr_i <= `MPW_BANK_HI) begin
      region = MPW_RG_BANK;
    end else if (dat_addr_i <= `MPW_WIN_HI) begin
      region = MPW_RG_WIN;
    end else if (dat_addr_i >= `MPW_RAM_LO && dat_addr_i <= `MPW_RAM_HI) begin
      region = MPW_RG_GPRAM;
    end else if (dat_addr_i == `MPW_ADDR_WIN_BASE || dat_addr_i == `MPW_ADDR_PAGE_SEL) begin
      region = MPW_RG_REG;
    end
  end

  // bit instructions on the write-only registers are ignored
  assign wr_page = dat_wr_i && !dat_bitop_i && dat_addr_i == `MPW_ADDR_PAGE_SEL;
  assign wr_base = dat_wr_i && !dat_bitop_i && dat_addr_i == `MPW_ADDR_WIN_BASE;
  assign win_rd = dat_rd_i && region == MPW_RG_WIN;

  // write-only registers: no reset, only a core write changes them
  always_comb begin
    page_d = page_q;
    base_d = base_q;
    if (wr_page) begin
      page_d = dat_wdata_i[`MPW_PAGE_W-1:0];
    end
    if (wr_base) begin
      base_d = dat_wdata_i[`MPW_WIN_BASE_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    page_q <= page_d;
    base_q <= base_d;
  end

  // fetch mapping
  assign eff_page = pc_i[`MPW_PC_STATIC_BIT] ? `MPW_STATIC_PAGE : page_q;
  assign fetch_addr_o = {eff_page, pc_i[`MPW_PAGE_OFS_W-1:0]};

  // window has the second port; external readout waits for it
  assign rom_b_addr_o = win_rd ? {base_q, dat_addr_i[`MPW_WIN_OFS_W-1:0]} : ext_addr_i;
  assign ext_rd_ack_o = ext_rd_i && !win_rd;

  // banked region: only a single selected bank is honoured
  assign bank_one = bank_sel_i != '0 && (bank_sel_i & (bank_sel_i - `MPW_BSEL_W'(1))) == '0;
  assign bank_ram_sel = bank_one && (bank_sel_i[`MPW_BSEL_RAM1] || bank_sel_i[`MPW_BSEL_RAM2]
    || bank_sel_i[`MPW_BSEL_LCD1] || bank_sel_i[`MPW_BSEL_LCD2]);

  always_comb begin
    bank_idx = `MPW_BIDX_RAM1;
    if (bank_sel_i[`MPW_BSEL_RAM2]) begin
      bank_idx = `MPW_BIDX_RAM2;
    end else if (bank_sel_i[`MPW_BSEL_LCD1]) begin
      bank_idx = `MPW_BIDX_LCD1;
    end else if (bank_sel_i[`MPW_BSEL_LCD2]) begin
      bank_idx = `MPW_BIDX_LCD2;
    end
  end

  assign eep_cs_o = region == MPW_RG_BANK && bank_one && (dat_rd_i || dat_wr_i)
    && (bank_sel_i[`MPW_BSEL_EEP0] || bank_sel_i[`MPW_BSEL_EEP1]);
  assign eep_we_o = eep_cs_o && dat_wr_i;
  assign eep_page_o = bank_sel_i[`MPW_BSEL_EEP1];
  assign eep_addr_o = dat_addr_i[`MPW_WIN_OFS_W-1:0];
  assign eep_wdata_o = dat_wdata_i;

  assign gp_ofs = dat_addr_i - `MPW_RAM_LO;

  mpw_data_ram #(
    .DEPTH(`MPW_GP_RAM_BYTES),
    .AW(`MPW_GP_RAM_AW),
    .DW(`MPW_DAT_W)
  ) u_gp_ram (
    .clk_i(clk_i),
    .we_i(dat_wr_i && region == MPW_RG_GPRAM),
    .waddr_i(gp_ofs[`MPW_GP_RAM_AW-1:0]),
    .wdata_i(dat_wdata_i),
    .raddr_i(gp_ofs[`MPW_GP_RAM_AW-1:0]),
    .rdata_o(gp_rdata)
  );

  mpw_data_ram #(
    .DEPTH(`MPW_BANK_RAM_BYTES),
    .AW(`MPW_BANK_RAM_AW),
    .DW(`MPW_DAT_W)
  ) u_bank_ram (
    .clk_i(clk_i),
    .we_i(dat_wr_i && region == MPW_RG_BANK && bank_ram_sel),
    .waddr_i({bank_idx, dat_addr_i[`MPW_WIN_OFS_W-1:0]}),
    .wdata_i(dat_wdata_i),
    .raddr_i({bank_idx, dat_addr_i[`MPW_WIN_OFS_W-1:0]}),
    .rdata_o(bank_rdata)
  );

  mpw_stack #(
    .WIDTH(`MPW_PC_W),
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .push_i(stk_push_i),
    .pop_i(stk_pop_i),
    .push_data_i(stk_push_data_i),
    .top_o(stk_top_o),
    .depth_o(stk_depth_o)
  );

  // read data: the write-only registers read as a miss with zero data
  always_comb begin
    rdata_d = '0;
    hit_d = 1'b0;
    if (dat_rd_i) begin
      unique case (region)
        MPW_RG_WIN: begin
          rdata_d = rom_b_data_i;
          hit_d = 1'b1;
        end
        MPW_RG_GPRAM: begin
          rdata_d = gp_rdata;
          hit_d = 1'b1;
        end
        MPW_RG_BANK: begin
          // no bank or several banks: nothing owns the byte, so it reads zero
          if (bank_one) begin
            rdata_d = bank_ram_sel ? bank_rdata : eep_rdata_i;
          end
          hit_d = bank_one;
        end
        MPW_RG_REG, MPW_RG_NONE: begin
          rdata_d = '0;
          hit_d = 1'b0;
        end
      endcase
    end
  end

  // protected parts hand out zeros, never the program
  always_comb begin
    ext_rdata_d = '0;
    if (ext_rd_ack_o && !prot_q) begin
      ext_rdata_d = rom_b_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prot_meta_q <= 1'b1;
      prot_q <= 1'b1;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      hit_q <= 1'b0;
      ext_rdata_q <= '0;
      ext_rvalid_q <= 1'b0;
      ext_denied_q <= 1'b0;
    end else begin
      prot_meta_q <= readout_prot_i;
      prot_q <= prot_meta_q;
      rdata_q <= rdata_d;
      rvalid_q <= dat_rd_i;
      hit_q <= hit_d;
      ext_rdata_q <= ext_rdata_d;
      ext_rvalid_q <= ext_rd_ack_o;
      ext_denied_q <= ext_rd_ack_o && prot_q;
    end
  end

  assign dat_rdata_o = rdata_q;
  assign dat_rvalid_o = rvalid_q;
  assign dat_hit_o = hit_q;
  assign ext_rdata_o = ext_rdata_q;
  assign ext_rvalid_o = ext_rvalid_q;
  assign ext_denied_o = ext_denied_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  page_write_a: assert property (
    wr_page |=> page_q == $past(dat_wdata_i[`MPW_PAGE_W-1:0]))
    else $error("page register did not take the written byte");
  page_hold_a: assert property (
    !wr_page ##1 stk_push_i |-> $stable(page_q))
    else $error("page register changed without a write");
  static_fetch_a: assert property (
    pc_i[`MPW_PC_STATIC_BIT] |-> fetch_addr_o[`MPW_PROG_AW-1 -: `MPW_PAGE_W] == `MPW_STATIC_PAGE)
    else $error("upper half fetch left the static page");
  low_fetch_a: assert property (
    !pc_i[`MPW_PC_STATIC_BIT] |-> fetch_addr_o == {page_q, pc_i[`MPW_PAGE_OFS_W-1:0]})
    else $error("lower half fetch ignored page bits");
  win_addr_a: assert property (
    win_rd |-> rom_b_addr_o == {base_q, dat_addr_i[`MPW_WIN_OFS_W-1:0]})
    else $error("window address not formed from base and offset");
  win_new_base_a: assert property (
    wr_base ##1 win_rd |-> rom_b_addr_o[`MPW_PROG_AW-1:`MPW_WIN_OFS_W]
      == $past(dat_wdata_i[`MPW_WIN_BASE_W-1:0]))
    else $error("window read used the old base");
  win_data_a: assert property (
    win_rd |=> dat_rvalid_o && dat_hit_o && dat_rdata_o == $past(rom_b_data_i))
    else $error("window read did not return program memory");
  base_bitop_a: assert property (
    dat_wr_i && dat_bitop_i && dat_addr_i == `MPW_ADDR_WIN_BASE |=> $stable(base_q))
    else $error("bit instruction changed window base");
  prot_block_a: assert property (
    ext_rd_ack_o && prot_q |=> ext_rdata_o == '0 && ext_denied_o)
    else $error("protected program memory was read out");
  eep_bank_a: assert property (
    eep_cs_o |-> dat_addr_i <= `MPW_BANK_HI && $onehot(bank_sel_i)
      && (bank_sel_i[`MPW_BSEL_EEP0] || bank_sel_i[`MPW_BSEL_EEP1]))
    else $error("eeprom selected outside the banked region");

  cover property (wr_base ##1 win_rd);
  cover property (pc_i[`MPW_PC_STATIC_BIT] ##1 !pc_i[`MPW_PC_STATIC_BIT]);
  cover property (ext_rd_ack_o && prot_q);
  cover property (dat_rd_i && region == MPW_RG_GPRAM);
endmodule : mpw_top
`default_nettype wire

/* pkg/mpw_params.svh */
// constants of the memory paging and data window block
// assumes an 8-bit data space and a 12-bit program counter
`ifndef MPW_PARAMS_SVH
`define MPW_PARAMS_SVH

// data space map
`define MPW_ADDR_WIN_BASE 8'hC9
`define MPW_ADDR_PAGE_SEL 8'hCA
`define MPW_BANK_HI 8'h3F
`define MPW_WIN_HI 8'h7F
`define MPW_RAM_LO 8'h84
`define MPW_RAM_HI 8'hBF

// sizes
`define MPW_DAT_W 8
`define MPW_PC_W 12
`define MPW_PROG_AW 13
`define MPW_WIN_OFS_W 6
`define MPW_WIN_BASE_W 7
`define MPW_PAGE_W 2
`define MPW_PAGE_OFS_W 11
`define MPW_GP_RAM_BYTES 60
`define MPW_GP_RAM_AW 6
`define MPW_BANK_RAM_BYTES 256
`define MPW_BANK_RAM_AW 8
`define MPW_STACK_DEPTH 6

// program counter bit that selects the static page, and that page
`define MPW_PC_STATIC_BIT 11
`define MPW_STATIC_PAGE 2'h1

// positions in the one-hot bank select
`define MPW_BSEL_W 7
`define MPW_BSEL_EEP0 0
`define MPW_BSEL_EEP1 1
`define MPW_BSEL_RAM1 3
`define MPW_BSEL_RAM2 4
`define MPW_BSEL_LCD1 5
`define MPW_BSEL_LCD2 6

// bank ram index of each bank
`define MPW_BIDX_RAM1 2'h0
`define MPW_BIDX_RAM2 2'h1
`define MPW_BIDX_LCD1 2'h2
`define MPW_BIDX_LCD2 2'h3

`endif

/* pkg/mpw_pkg.sv */
// types of the memory paging and data window block
// assumes mpw_params.svh is on the include path
package mpw_pkg;
  // region of the data space hit by the current access
  typedef enum logic [4:0] {
    MPW_RG_NONE = 5'h01,
    MPW_RG_BANK = 5'h02,
    MPW_RG_WIN = 5'h04,
    MPW_RG_GPRAM = 5'h08,
    MPW_RG_REG = 5'h10
  } mpw_region_e;
endpackage : mpw_pkg

/* rtl/mpw_data_ram.sv */
// byte-wide ram with one write port and one combinational read port
// assumes one clock; contents are not cleared by reset
`timescale 1ns/10ps
`default_nettype none
module mpw_data_ram #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW = 6,
  parameter int unsigned DW = 8
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i && (32'(waddr_i) < DEPTH)) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // out-of-range addresses read zero rather than an undefined entry
  assign rdata_o = (32'(raddr_i) < DEPTH) ? mem_q[raddr_i] : '0;
endmodule : mpw_data_ram
`default_nettype wire

/* rtl/mpw_stack.sv */
// return address stack: push shifts down, pop shifts up
// assumes the core never pushes and pops in one cycle except to replace the top
`timescale 1ns/10ps
`default_nettype none
module mpw_stack #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 6,
  parameter int unsigned CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [WIDTH-1:0] push_data_i,
  output logic [WIDTH-1:0] top_o,
  output logic [CW-1:0] depth_o
);
  logic [WIDTH-1:0] ent_q [DEPTH];
  logic [WIDTH-1:0] ent_d [DEPTH];
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    for (int i = 0; i < DEPTH; i++) begin
      ent_d[i] = ent_q[i];
    end
    if (push_i && pop_i) begin
      ent_d[0] = push_data_i;
    end else if (push_i) begin
      // a seventh push drops the oldest entry
      for (int i = DEPTH - 1; i > 0; i--) begin
        ent_d[i] = ent_q[i-1];
      end
      ent_d[0] = push_data_i;
      if (32'(cnt_q) < DEPTH) begin
        cnt_d = cnt_q + CW'(1);
      end
    end else if (pop_i) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        ent_d[i] = ent_q[i+1];
      end
      ent_d[DEPTH-1] = '0;
      if (cnt_q != '0) begin
        cnt_d = cnt_q - CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        ent_q[i] <= '0;
      end
    end else begin
      cnt_q <= cnt_d;
      for (int i = 0; i < DEPTH; i++) begin
        ent_q[i] <= ent_d[i];
      end
    end
  end

  assign top_o = ent_q[0];
  assign depth_o = cnt_q;

  stack_push_a: assert property (@(posedge clk_i) disable iff (srst_i)
    push_i && !pop_i |=> top_o == $past(push_data_i) && depth_o != '0)
    else $error("pushed return address not on top");
  cover property (@(posedge clk_i) disable iff (srst_i) 32'(depth_o) == DEPTH);
endmodule : mpw_stack
`default_nettype wire

/* testbench/mpw_mem_model.sv */
// program memory port and eeprom stand-ins, both answering in the same cycle
// assumes addresses are settled well before the edge that takes them
`timescale 1ns/10ps
`default_nettype none
module mpw_mem_model (
  input wire logic clk_i,
  input wire logic [12:0] rom_b_addr_i,
  output logic [7:0] rom_b_data_o,
  input wire logic eep_cs_i,
  input wire logic eep_page_i,
  input wire logic [5:0] eep_addr_i,
  output logic [7:0] eep_rdata_o
);
  logic [7:0] junk_q = 8'h5A;
  // unselected eeprom shows a moving pattern, never a held byte
  always_ff @(posedge clk_i) begin
    junk_q <= {junk_q[6:0], ~junk_q[7]};
  end
  assign rom_b_data_o = rom_b_addr_i[7:0] ^ {rom_b_addr_i[12:8], 3'h5};
  assign eep_rdata_o = eep_cs_i ? {1'b1, eep_page_i, eep_addr_i} : junk_q;
endmodule : mpw_mem_model
`default_nettype wire

/* testbench/test_mpw_top.sv */
// self-checking bench of paging, data window, stack and readout blocking
// assumes mpw_params.svh on the include path and the memory model beside it
`timescale 1ns/10ps
`default_nettype none
`include "mpw_params.svh"
module test_mpw_top import mpw_pkg::*;;
  logic clk_i = 0, srst_i = 1, dat_wr_i = 0, dat_rd_i = 0, dat_bitop_i = 0;
  logic [7:0] dat_addr_i = 0, dat_wdata_i = 0, dat_rdata_o, eep_wdata_o, eep_rdata_i;
  logic [7:0] rom_b_data_i, ext_rdata_o;
  logic dat_rvalid_o, dat_hit_o, eep_cs_o, eep_we_o, eep_page_o, ext_rd_ack_o;
  logic readout_prot_i = 1, ext_rd_i = 0, ext_rvalid_o, ext_denied_o;
  logic stk_push_i = 0, stk_pop_i = 0;
  logic [6:0] bank_sel_i = 0, sel = 0, base = 0, b7;
  logic [5:0] eep_addr_o;
  logic [11:0] pc_i = 12'h800, stk_push_data_i = 0, stk_top_o; // static page until pc_chk drives a new pc
  logic [12:0] fetch_addr_o, rom_b_addr_o, ext_addr_i = 0;
  logic [2:0] stk_depth_o;
  logic [1:0] pg = 0;
  logic [31:0] rnd = 32'h3B3C;
  logic [8:0] dq[$], eq[$];
  int err_count = 0, total_checks = 0;

  always #25 clk_i = ~clk_i;

  mpw_top u_mpw_top (.clk_i(clk_i), .srst_i(srst_i), .dat_wr_i(dat_wr_i),
    .dat_rd_i(dat_rd_i), .dat_bitop_i(dat_bitop_i), .dat_addr_i(dat_addr_i),
    .dat_wdata_i(dat_wdata_i), .dat_rdata_o(dat_rdata_o), .dat_rvalid_o(dat_rvalid_o),
    .dat_hit_o(dat_hit_o), .bank_sel_i(bank_sel_i), .eep_cs_o(eep_cs_o),
    .eep_we_o(eep_we_o), .eep_page_o(eep_page_o), .eep_addr_o(eep_addr_o),
    .eep_wdata_o(eep_wdata_o), .eep_rdata_i(eep_rdata_i), .pc_i(pc_i),
    .fetch_addr_o(fetch_addr_o), .rom_b_addr_o(rom_b_addr_o),
    .rom_b_data_i(rom_b_data_i), .readout_prot_i(readout_prot_i), .ext_rd_i(ext_rd_i),
    .ext_addr_i(ext_addr_i), .ext_rd_ack_o(ext_rd_ack_o), .ext_rdata_o(ext_rdata_o),
    .ext_rvalid_o(ext_rvalid_o), .ext_denied_o(ext_denied_o), .stk_push_i(stk_push_i),
    .stk_pop_i(stk_pop_i), .stk_push_data_i(stk_push_data_i), .stk_top_o(stk_top_o),
    .stk_depth_o(stk_depth_o));

  mpw_mem_model u_mpw_mem_model (.clk_i(clk_i), .rom_b_addr_i(rom_b_addr_o),
    .rom_b_data_o(rom_b_data_i), .eep_cs_i(eep_cs_o), .eep_page_i(eep_page_o),
    .eep_addr_i(eep_addr_o), .eep_rdata_o(eep_rdata_i));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  function automatic logic [7:0] ro(input logic [12:0] a);
    return a[7:0] ^ {a[12:8], 3'h5};
  endfunction : ro

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt

  // request is taken at the next edge; no clearing, so calls run back to back
  task automatic acc(input logic w, r, b, input logic [7:0] a, d, input logic [8:0] e);
    @(posedge clk_i);
    dat_wr_i <= w;
    dat_rd_i <= r;
    dat_bitop_i <= b;
    dat_addr_i <= a;
    dat_wdata_i <= d;
    bank_sel_i <= sel;
    if (r) dq.push_back(e);
  endtask : acc

  task automatic pc_chk(input logic [11:0] p);
    @(posedge clk_i);
    pc_i <= p;
    @(negedge clk_i);
    chk(fetch_addr_o, p[11] ? {2'h1, p[10:0]} : {pg, p[10:0]});
  endtask : pc_chk

  task automatic stk(input logic u, o, input logic [11:0] d);
    @(posedge clk_i);
    stk_push_i <= u;
    stk_pop_i <= o;
    stk_push_data_i <= d;
  endtask : stk

  // request held until acknowledged, bounded wait
  task automatic ext(input logic [12:0] a, input logic p);
    @(posedge clk_i);
    ext_rd_i <= 1;
    ext_addr_i <= a;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk_i);
      if (ext_rd_ack_o === 1'b1) break;
      if (n == 7) begin
        $display("[ERR] %0t readout never acknowledged", $time);
        err_count++;
        give_verdict();
      end
    end
    eq.push_back(p ? 9'h100 : {1'b0, ro(a)});
    ext_rd_i <= 0;
  endtask : ext

  always @(negedge clk_i) begin
    if (dat_rd_i === 1'b1 && dat_addr_i[7:6] == 2'h1) chk(rom_b_addr_o, {base, dat_addr_i[5:0]});
    if (dat_rvalid_o === 1'b1) begin
      if (dq.size() == 0) chk(0, 1);
      else chk({dat_hit_o, dat_rdata_o}, dq.pop_front());
    end
    if (ext_rvalid_o === 1'b1) begin
      if (eq.size() == 0) chk(0, 1);
      else chk({ext_denied_o, ext_rdata_o}, eq.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    $display("[ERR] %0t run hung", $time);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    chk({stk_depth_o, dat_rvalid_o, ext_rvalid_o}, 0);
    srst_i <= 0;
    acc(1, 0, 0, `MPW_ADDR_WIN_BASE, 0, 0);
    for (int i = 0; i < 4; i++) begin
      rnd = nxt(rnd);
      acc(1, 0, 0, `MPW_ADDR_PAGE_SEL, {rnd[7:2], i[1:0]}, 0);
      pg = i[1:0];
      acc(1, 0, 1, `MPW_ADDR_PAGE_SEL, ~{rnd[7:2], i[1:0]}, 0);
      acc(0, 0, 0, 0, 0, 0);
      pc_chk(rnd[11:0] & 12'h7FF);
      pc_chk(rnd[11:0] | 12'h800);
    end
    acc(0, 1, 0, `MPW_ADDR_PAGE_SEL, 0, 0);
    acc(0, 1, 0, `MPW_ADDR_WIN_BASE, 0, 0);
    endt("paging");
    for (int i = 0; i < 4; i++) begin
      rnd = nxt(rnd);
      b7 = i == 0 ? 7'h00 : i == 1 ? 7'h7F : rnd[14:8];
      acc(1, 0, 0, 8'h85, {rnd[15], b7}, 0);
      acc(1, 0, 0, `MPW_ADDR_WIN_BASE, {rnd[15], b7}, 0);
      base = b7;
      acc(0, 1, 0, {2'h1, rnd[21:16]}, 0, {1'b1, ro({b7, rnd[21:16]})});
      acc(0, 1, 0, `MPW_WIN_HI, 0, {1'b1, ro({b7, 6'h3F})});
      acc(1, 0, 1, `MPW_ADDR_WIN_BASE, 8'h55, 0);
      acc(0, 1, 0, 8'h40, 0, {1'b1, ro({b7, 6'h00})});
    end
    acc(0, 0, 0, 0, 0, 0);
    endt("window");
    for (int i = 3; i < 7; i++) begin
      sel = 7'h01 << i;
      acc(1, 0, 0, 8'h20, 8'hA0 + i[7:0], 0);
    end
    for (int i = 3; i < 7; i++) begin
      sel = 7'h01 << i;
      acc(0, 1, 0, 8'h20, 0, {1'b1, 8'hA0 + i[7:0]});
    end
    for (int i = 0; i < 2; i++) begin
      sel = 7'h01 << i;
      acc(0, 1, 0, 8'h2A, 0, {2'h3, i[0], 6'h2A});
    end
    acc(0, 1, 0, 8'h85, 0, {1'b1, rnd[15], b7});
    rnd = nxt(rnd);
    sel = 7'h01;
    acc(1, 0, 0, 8'h15, rnd[23:16], 0);
    @(negedge clk_i);
    chk({eep_we_o, eep_page_o, eep_addr_o, eep_wdata_o}, {2'h2, 6'h15, rnd[23:16]});
    sel = 7'h18;
    acc(0, 1, 0, 8'h20, 0, 9'h000);
    rnd = nxt(rnd);
    acc(1, 0, 0, 8'h84, rnd[7:0], 0);
    acc(1, 0, 0, 8'hBF, rnd[15:8], 0);
    acc(0, 1, 0, 8'h84, 0, {1'b1, rnd[7:0]});
    acc(0, 1, 0, 8'hBF, 0, {1'b1, rnd[15:8]});
    acc(0, 0, 0, 0, 0, 0);
    endt("data ram");
    for (int i = 0; i < 7; i++) stk(1, 0, 12'h100 + i[11:0]);
    stk(0, 0, 0);
    @(negedge clk_i);
    chk({stk_depth_o, stk_top_o}, {3'h6, 12'h106});
    stk(0, 1, 0);
    stk(0, 0, 0);
    @(negedge clk_i);
    chk({stk_depth_o, stk_top_o}, {3'h5, 12'h105});
    pc_chk(12'h123);
    endt("stack");
    @(posedge clk_i);
    readout_prot_i <= 0;
    repeat (4) @(posedge clk_i);
    ext(13'h1ABC, 0);
    fork
      ext(13'h0F05, 0);
      begin
        acc(0, 1, 0, 8'h41, 0, {1'b1, ro({base, 6'h01})});
        acc(0, 0, 0, 0, 0, 0);
      end
    join
    @(posedge clk_i);
    readout_prot_i <= 1;
    repeat (4) @(posedge clk_i);
    ext(13'h1ABC, 1);
    repeat (3) @(posedge clk_i);
    chk(dq.size() + eq.size(), 0);
    endt("readout");
    give_verdict();
  end
endmodule : test_mpw_top
`default_nettype wire
